// File: sp1_serial_port.sv
// Behaviour
// - Transmit-empty flag sets when held byte moves into the shift register.
// - Shift-complete flag reads one once a whole byte is shifted out.
// - Receive-full flag sets on a complete byte, clears on buffer read.
// - Control bits select mode, enable port, transmitter and receiver.
// - Count source picks undivided or divided-by-4 oscillator; internal sync clock is divider/4.
// - Sync internal clock: writing transmit data starts shifting, receive too.
// - Master transfer of a byte begins on the transmit data write.
// - External clock: port always accepts the incoming clock, no trigger.
// - External clock: receive interrupt after every eight clock pulses.
// - Master: received byte valid no later than transmit interrupt.
// - Synchronous bytes go out least significant bit first.
// - Async bit rate is oscillator / ((divider+1) x 16 x m).
//
// Our own choice: the APB interface to the registers.
module sp1_serial_port #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   txd_out,
  output logic                   txd_oe,
  input  wire logic              rxd_in,
  input  wire logic              sclk_in,
  output logic                   sclk_out,
  output logic                   sclk_oe,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  sp1_pkg::sp1_ctrl_t     ctrl;
  sp1_pkg::sp1_rx_state_t rx_state;
  logic [7:0] divider;
  logic [7:0] edge_sel;
  logic [7:0] tx_buf;
  logic [7:0] rx_buf;
  logic [7:0] tx_sh;
  logic [9:0] frame_sh;
  logic [7:0] rx_sh;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic       tx_empty;
  logic       rx_full;
  logic       tx_shift_done;
  logic       overrun;
  logic       tx_busy;
  logic       txd_q;
  logic       sclk_q;
  logic       sclk_in_q;
  logic [1:0] pre_cnt;
  logic [7:0] brg_cnt;
  logic       half_cnt;
  logic [3:0] os_cnt;
  logic [3:0] frame_cnt;
  logic [2:0] sync_cnt;
  logic [3:0] rx_os;
  logic [2:0] rx_bit;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [7:0] idx;
  logic       mapped;
  logic       access;
  logic       wr;
  logic       rd;
  logic       wr_data;
  logic       rd_data;

  assign idx     = paddr[9:2];
  assign mapped  = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0) &&
                   (idx == sp1_pkg::IDX_DATA || idx == sp1_pkg::IDX_STATUS ||
                    idx == sp1_pkg::IDX_CONTROL ||
                    idx == sp1_pkg::IDX_DIVIDER ||
                    idx == sp1_pkg::IDX_IRQ_STAT ||
                    idx == sp1_pkg::IDX_IRQ_MASK ||
                    idx == sp1_pkg::IDX_EDGE_SEL);
  assign access  = psel && penable;
  assign wr      = access && pwrite && mapped;
  assign rd      = access && !pwrite && mapped;
  assign wr_data = wr && (idx == sp1_pkg::IDX_DATA);
  assign rd_data = rd && (idx == sp1_pkg::IDX_DATA);
  assign pready  = 1'b1;                   // Zero wait states
  assign pslverr = access && !mapped;      // Unmapped or misaligned

  // ----------------------------------------------------------------
  // Rate generation
  // ----------------------------------------------------------------
  logic pre_en;
  logic brg_tick;
  logic half_tick;
  logic bit_tick;

  // bit 0 set gives m of four
  assign pre_en    = ctrl.port_en &&
                     (!ctrl.src_div4 || pre_cnt == sp1_pkg::PRESCALE_LAST);
  assign brg_tick  = pre_en && (brg_cnt == 8'h00);
  assign half_tick = brg_tick && half_cnt;
  assign bit_tick  = brg_tick && (os_cnt == sp1_pkg::OVERSAMPLE_LAST);

  // Prescaler and reloading baud divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt  <= 2'h0;
      brg_cnt  <= 8'h00;
      half_cnt <= 1'b0;
    end else if (!ctrl.port_en) begin
      pre_cnt  <= 2'h0;
      brg_cnt  <= divider;
      half_cnt <= 1'b0;
    end else begin
      pre_cnt <= pre_cnt + 2'h1;
      if (pre_en) begin
        brg_cnt <= (brg_cnt == 8'h00) ? divider : brg_cnt - 8'h01;
      end
      if (brg_tick) begin
        half_cnt <= !half_cnt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer control
  // ----------------------------------------------------------------
  logic sync_mode;
  logic async_on;
  logic rise;
  logic fall;
  logic sync_done;
  logic tx_load;
  logic tx_done;
  logic rx_async_done;
  logic rx_done;
  logic [7:0] rx_next;

  assign sync_mode = ctrl.port_en && !ctrl.async_mode;
  assign async_on  = ctrl.port_en && ctrl.async_mode;
  assign rise = ctrl.int_clk ? (tx_busy && half_tick && !sclk_q)
                             : (sclk_in && !sclk_in_q);
  assign fall = ctrl.int_clk ? (tx_busy && half_tick && sclk_q)
                             : (!sclk_in && sclk_in_q);
  assign sync_done = sync_mode && rise && (sync_cnt == sp1_pkg::BYTE_LAST);
  // move held byte when shifter is free
  assign tx_load = !tx_empty && !tx_busy && ctrl.tx_en && ctrl.port_en &&
                   (ctrl.async_mode || sync_cnt == 3'h0);
  assign tx_done = tx_busy &&
                   (ctrl.async_mode
                      ? (bit_tick && frame_cnt == sp1_pkg::FRAME_LAST)
                      : sync_done);
  assign rx_async_done = async_on && (rx_state == sp1_pkg::RX_STOP) &&
                         brg_tick && (rx_os == sp1_pkg::OVERSAMPLE_LAST);
  assign rx_done = ctrl.rx_en && (ctrl.async_mode ? rx_async_done : sync_done);
  assign rx_next = ctrl.async_mode ? rx_sh : {rxd_in, rx_sh[7:1]};

  // Transmit shifter, shift clock and transmit pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy   <= 1'b0;
      tx_sh     <= 8'h00;
      frame_sh  <= 10'h3FF;
      frame_cnt <= 4'h0;
      os_cnt    <= 4'h0;
      sync_cnt  <= 3'h0;
      txd_q     <= 1'b1;
      sclk_q    <= 1'b1;
      sclk_in_q <= 1'b1;
    end else begin
      sclk_in_q <= sclk_in;
      if (!ctrl.port_en) begin
        tx_busy  <= 1'b0;
        sync_cnt <= 3'h0;
        sclk_q   <= 1'b1;
        txd_q    <= 1'b1;
      end else if (tx_load) begin
        tx_busy   <= 1'b1;
        tx_sh     <= tx_buf;
        frame_sh  <= {1'b1, tx_buf, 1'b0};
        frame_cnt <= 4'h0;
        os_cnt    <= 4'h0;
      end else if (ctrl.async_mode) begin
        if (brg_tick) begin
          os_cnt <= os_cnt + 4'h1;
        end
        if (tx_busy) begin
          txd_q <= frame_sh[0];
        end
        if (bit_tick && tx_busy) begin
          frame_sh  <= {1'b1, frame_sh[9:1]};
          frame_cnt <= frame_cnt + 4'h1;
        end
        if (tx_done) begin
          tx_busy <= 1'b0;
        end
      end else begin
        if (ctrl.int_clk && tx_busy && half_tick) begin
          sclk_q <= !sclk_q;
        end
        if (fall) begin
          txd_q <= tx_sh[0];
        end
        if (rise) begin
          tx_sh    <= {1'b1, tx_sh[7:1]};
          sync_cnt <= sync_cnt + 3'h1;
        end
        if (tx_done) begin
          tx_busy <= 1'b0;
        end
      end
    end
  end

  // Receive shifter, both modes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= sp1_pkg::RX_IDLE;
      rx_sh    <= 8'h00;
      rx_os    <= 4'h0;
      rx_bit   <= 3'h0;
    end else if (!async_on) begin
      rx_state <= sp1_pkg::RX_IDLE;
      if (sync_mode && rise) begin
        rx_sh <= {rxd_in, rx_sh[7:1]};
      end
    end else begin
      if (brg_tick) begin
        rx_os <= rx_os + 4'h1;
      end
      case (rx_state)
        sp1_pkg::RX_IDLE: begin
          if (ctrl.rx_en && !rxd_in) begin
            rx_state <= sp1_pkg::RX_START;
            rx_os    <= 4'h0;
          end
        end
        sp1_pkg::RX_START: begin
          if (brg_tick && rx_os == sp1_pkg::MID_BIT) begin
            rx_os    <= 4'h0;
            rx_bit   <= 3'h0;
            rx_state <= rxd_in ? sp1_pkg::RX_IDLE : sp1_pkg::RX_DATA;
          end
        end
        sp1_pkg::RX_DATA: begin
          if (brg_tick && rx_os == sp1_pkg::OVERSAMPLE_LAST) begin
            rx_sh  <= {rxd_in, rx_sh[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == sp1_pkg::BYTE_LAST) begin
              rx_state <= sp1_pkg::RX_STOP;
            end
          end
        end
        sp1_pkg::RX_STOP: begin
          if (rx_async_done) begin
            rx_state <= sp1_pkg::RX_IDLE;
          end
        end
        default: rx_state <= sp1_pkg::RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flags and buffers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_buf        <= 8'h00;
      rx_buf        <= 8'h00;
      tx_empty      <= 1'b1;
      tx_shift_done <= 1'b1;
      rx_full       <= 1'b0;
      overrun       <= 1'b0;
    end else begin
      if (wr_data) begin
        tx_buf <= pwdata[7:0];
      end
      if (tx_load) begin
        tx_empty <= 1'b1;
      end else if (wr_data) begin
        tx_empty <= 1'b0;
      end
      if (tx_done) begin
        tx_shift_done <= 1'b1;
      end else if (tx_load) begin
        tx_shift_done <= 1'b0;
      end
      if (rx_done) begin
        rx_buf  <= rx_next;
        rx_full <= 1'b1;
      end else if (rd_data) begin
        rx_full <= 1'b0;
      end
      if (rx_done && rx_full && !rd_data) begin
        overrun <= 1'b1;
      end else if (wr && idx == sp1_pkg::IDX_STATUS) begin
        overrun <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration and interrupt registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl     <= sp1_pkg::CONTROL_RST;
      divider  <= sp1_pkg::DIVIDER_RST;
      edge_sel <= sp1_pkg::EDGE_SEL_RST;
      irq_mask <= sp1_pkg::IRQ_MASK_RST;
    end else if (wr) begin
      case (idx)
        sp1_pkg::IDX_CONTROL:  ctrl     <= pwdata[7:0];
        sp1_pkg::IDX_DIVIDER:  divider  <= pwdata[7:0];
        sp1_pkg::IDX_EDGE_SEL: edge_sel <= pwdata[7:0];
        sp1_pkg::IDX_IRQ_MASK: irq_mask <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Sticky events, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat[sp1_pkg::IRQ_RX] <= rx_done ||
        (irq_stat[sp1_pkg::IRQ_RX] &&
         !(wr && idx == sp1_pkg::IDX_IRQ_STAT && pwdata[sp1_pkg::IRQ_RX]));
      irq_stat[sp1_pkg::IRQ_TX] <= tx_done ||
        (irq_stat[sp1_pkg::IRQ_TX] &&
         !(wr && idx == sp1_pkg::IDX_IRQ_STAT && pwdata[sp1_pkg::IRQ_TX]));
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // Read data captured in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (idx)
        sp1_pkg::IDX_DATA:     prdata <= {24'h000000, rx_buf};
        sp1_pkg::IDX_STATUS:   prdata <= {28'h0000000, overrun,
                                          tx_shift_done, rx_full, tx_empty};
        sp1_pkg::IDX_CONTROL:  prdata <= {24'h000000, ctrl};
        sp1_pkg::IDX_DIVIDER:  prdata <= {24'h000000, divider};
        sp1_pkg::IDX_IRQ_STAT: prdata <= {30'h00000000, irq_stat};
        sp1_pkg::IDX_IRQ_MASK: prdata <= {30'h00000000, irq_mask};
        sp1_pkg::IDX_EDGE_SEL: prdata <= {24'h000000, edge_sel};
        default:               prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign txd_out  = txd_q;
  assign txd_oe   = ctrl.port_en && ctrl.tx_en;
  assign sclk_out = sclk_q;
  assign sclk_oe  = sync_mode && ctrl.int_clk;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_TX_EMPTY_SET:
    assert property (tx_load |=> tx_empty && tx_busy)
    else $error("transmit empty not set on move");

  AST_TX_EMPTY_CLR:
    assert property (wr_data && !tx_load |=> !tx_empty ##0 tx_buf ==
                     $past(pwdata[7:0]))
    else $error("transmit empty not cleared on write");

  AST_SHIFT_DONE:
    assert property (tx_done |=> tx_shift_done && !tx_busy)
    else $error("shift completion missing");

  AST_RX_FULL_SET:
    assert property (rx_done |=> rx_full)
    else $error("receive full not set");

  AST_RX_FULL_CLR:
    assert property (rd_data && !rx_done |=> !rx_full)
    else $error("receive full not cleared by read");

  AST_EXT_COUNT:
    assert property (sync_mode && !ctrl.int_clk && rise && !wr |=>
                     sync_cnt == $past(sync_cnt) + 3'h1)
    else $error("external clock edge not counted");

  AST_RX_EVENT:
    assert property (sync_mode && !ctrl.int_clk && ctrl.rx_en && rise &&
                     sync_cnt == 3'h7 |=> irq_stat[sp1_pkg::IRQ_RX])
    else $error("receive event missing after eight clocks");

  AST_RX_BEFORE_TX:
    assert property ($rose(irq_stat[sp1_pkg::IRQ_TX]) && sync_mode &&
                     ctrl.rx_en |-> rx_full)
    else $error("receive byte late against transmit event");

  AST_LSB_FIRST:
    assert property (sync_mode && fall && !tx_load |=>
                     txd_out == $past(tx_sh[0]))
    else $error("bit order wrong");

  AST_BRG_RATE:
    assert property (brg_tick && !ctrl.src_div4 && divider == 8'h01 &&
                     ctrl.port_en && !wr |=> !brg_tick ##1 brg_tick)
    else $error("divider rate wrong");

endmodule : sp1_serial_port

// File: sp1_pkg.sv
package sp1_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_DATA      = 8'h18;
  localparam logic [7:0] IDX_STATUS    = 8'h19;
  localparam logic [7:0] IDX_CONTROL   = 8'h1A;
  localparam logic [7:0] IDX_DIVIDER   = 8'h1C;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h21;
  localparam logic [7:0] IDX_EDGE_SEL  = 8'h3A;

  // ----------------------------------------------------------------
  // Status and interrupt field positions
  // ----------------------------------------------------------------
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_RX_FULL  = 1;
  localparam int ST_TX_DONE  = 2;
  localparam int ST_OVERRUN  = 3;
  localparam int IRQ_RX      = 0;
  localparam int IRQ_TX      = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] DIVIDER_RST  = 8'h00;
  localparam logic [7:0] EDGE_SEL_RST = 8'h00;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam logic [1:0] PRESCALE_LAST = 2'h3;  // Source divided by 4
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF; // 16 ticks per bit
  localparam logic [3:0] MID_BIT       = 4'h7;
  localparam logic [3:0] FRAME_LAST    = 4'h9;  // Start, 8 data, stop
  localparam logic [2:0] BYTE_LAST     = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic port_en;     // [7] Whole port enable
    logic async_mode;  // [6] 1: asynchronous, 0: clock synchronous
    logic rx_en;       // [5] Receiver enable
    logic tx_en;       // [4] Transmitter enable
    logic [1:0] spare; // [3:2] Read back as written
    logic int_clk;     // [1] 1: internal shift clock, 0: external
    logic src_div4;    // [0] 1: oscillator divided by 4, 0: undivided
  } sp1_ctrl_t;

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} sp1_rx_state_t;

endpackage : sp1_pkg

// File: sp1_peer.sv
module sp1_peer (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       arm,
  input  wire logic       cs_n,
  input  wire logic       ext_mode,
  input  wire logic [1:0] blk,
  input  wire logic [7:0] tx_byte,
  input  wire logic       sclk_line,
  input  wire logic       txd_line,
  output logic            sclk_drv,
  output logic            rxd,
  output logic [7:0]      got
);
  // ----------------------------------------------------------------
  // Far-side shifter
  // ----------------------------------------------------------------
  logic       s_q;
  logic       active;
  logic       gen;
  logic       fall;
  logic       rise;
  logic [2:0] bits;
  logic [2:0] tick;
  logic [1:0] nb;
  logic [7:0] sh;

  // Edges of the shared clock line
  assign fall = s_q & ~sclk_line;
  assign rise = ~s_q & sclk_line;

  // Clock generation, data out on falls, capture on rises
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q      <= 1'b1;
      active   <= 1'b0;
      gen      <= 1'b0;
      bits     <= 3'h0;
      tick     <= 3'h0;
      nb       <= 2'h0;
      sh       <= 8'h00;
      sclk_drv <= 1'b1;
      rxd      <= 1'b1;
      got      <= 8'h00;
    end else begin
      s_q <= sclk_line;
      if (arm) begin
        active <= 1'b1;
        gen    <= ext_mode;
        bits   <= 3'h0;
        tick   <= 3'h0;
        nb     <= 2'h0;
        sh     <= tx_byte;
      end else begin
        if (gen && active) begin
          tick <= tick + 3'h1;
          if (tick == 3'h7) sclk_drv <= ~sclk_drv;
        end
        // deselected far side ignores the link
        if (!active || cs_n) rxd <= ~rxd; // Released line keeps changing
        else if (fall) begin
          rxd <= sh[0];
          sh  <= sh >> 1;
        end else if (rise) begin
          got  <= {txd_line, got[7:1]};
          bits <= bits + 3'h1;
          // next byte ready before next clock
          if (bits == 3'h7) begin
            sh <= tx_byte;
            nb <= nb + 2'h1;
            if (nb == blk - 2'h1) active <= 1'b0;
          end
        end
      end
    end
  end
endmodule : sp1_peer

// File: tb_serial_port_one_sync_async.sv
module tb_serial_port_one_sync_async;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0;
  logic        arm      = 1'b0;
  logic        cs_n     = 1'b1;
  logic        ext_mode = 1'b0;
  logic [1:0]  blk      = 2'h1;
  logic [7:0]  tx_byte  = 8'h00;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        err;
  logic        pready;
  logic        pslverr;
  logic        txd_out;
  logic        txd_oe;
  logic        sclk_out;
  logic        sclk_oe;
  logic        irq;
  logic        sclk_drv;
  logic        rxd;
  logic [7:0]  got;
  logic        sclk_line;
  logic        txd_line;
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  int          cyc        = 0;

  // Shared clock line and pulled-up data line
  assign sclk_line = sclk_oe ? sclk_out : sclk_drv;
  assign txd_line  = txd_oe ? txd_out : 1'b1;

  always #4 clk = ~clk;

  sp1_serial_port #(.ADDR_W(12)) i_sp1_serial_port (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txd_out(txd_out),
    .txd_oe(txd_oe), .rxd_in(rxd), .sclk_in(sclk_line),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .irq(irq)
  );

  sp1_peer i_sp1_peer (
    .clk(clk), .rst_n(rst_n), .arm(arm), .cs_n(cs_n), .ext_mode(ext_mode),
    .blk(blk), .tx_byte(tx_byte), .sclk_line(sclk_line), .txd_line(txd_line),
    .sclk_drv(sclk_drv), .rxd(rxd), .got(got)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic peer_go(input logic em, input logic [1:0] b,
                         input logic [7:0] d);
    @(posedge clk);
    ext_mode <= em;
    blk      <= b;
    tx_byte  <= d;
    arm      <= 1'b1;
    // select low before the first byte
    cs_n     <= 1'b0;
    @(posedge clk);
    arm <= 1'b0;
  endtask : peer_go

  // Polls irq on falling edges, then one more edge for the far side
  task automatic wait_irq;
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk);
      if (irq === 1'b1) break;
    end
    if (irq !== 1'b1) n_mismatch++;
    @(negedge clk);
  endtask : wait_irq

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    apb(1'b0, sp1_pkg::IDX_STATUS, 32'h0);
    check(rd, 32'h5);
    apb(1'b0, sp1_pkg::IDX_CONTROL, 32'h0);
    check(rd, {24'h0, sp1_pkg::CONTROL_RST});
    apb(1'b0, 8'h30, 32'h0);
    check({rd[30:0], err}, 32'h1);
    check({31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // Back-to-back bytes as master with internal clock
  task automatic t_master;
    apb(1'b1, sp1_pkg::IDX_DIVIDER, 32'h1);
    apb(1'b1, sp1_pkg::IDX_IRQ_MASK, 32'h3);
    apb(1'b1, sp1_pkg::IDX_CONTROL, 32'hB3);
    peer_go(1'b0, 2'h2, 8'h3C);
    apb(1'b1, sp1_pkg::IDX_DATA, 32'hA5);
    apb(1'b1, sp1_pkg::IDX_DATA, 32'h96);
    apb(1'b0, sp1_pkg::IDX_STATUS, 32'h0);
    check({31'h0, rd[sp1_pkg::ST_TX_EMPTY]}, 32'h0);
    wait_irq();
    check({24'h0, got}, 32'hA5);
    apb(1'b0, sp1_pkg::IDX_STATUS, 32'h0);
    check({30'h0, rd[1:0]}, 32'h3);
    apb(1'b0, sp1_pkg::IDX_DATA, 32'h0);
    check(rd, 32'h3C);
    apb(1'b0, sp1_pkg::IDX_STATUS, 32'h0);
    check({31'h0, rd[sp1_pkg::ST_RX_FULL]}, 32'h0);
    apb(1'b1, sp1_pkg::IDX_IRQ_MASK, 32'h0);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, sp1_pkg::IDX_IRQ_STAT, 32'h3);
    apb(1'b1, sp1_pkg::IDX_IRQ_MASK, 32'h3);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    wait_irq();
    check({24'h0, got}, 32'h96);
    apb(1'b0, sp1_pkg::IDX_DATA, 32'h0);
    check(rd, 32'h3C);
    apb(1'b0, sp1_pkg::IDX_STATUS, 32'h0);
    check({31'h0, rd[sp1_pkg::ST_TX_DONE]}, 32'h1);
    apb(1'b1, sp1_pkg::IDX_IRQ_STAT, 32'h3);
    // select high after the last byte
    cs_n <= 1'b1;
    $display("test master done");
  endtask : t_master

  // Shift clock period for both count sources
  task automatic t_period;
    int n;
    for (int m = 4; m > 0; m = m - 3) begin
      apb(1'b1, sp1_pkg::IDX_CONTROL, (m == 4) ? 32'hB3 : 32'hB2);
      peer_go(1'b0, 2'h1, 8'h00);
      apb(1'b1, sp1_pkg::IDX_DATA, 32'h0);
      n = 0;
      while (sclk_out !== 1'b0 && n < 500) begin
        @(negedge clk);
        n++;
      end
      n = 0;
      while (sclk_out !== 1'b1 && n < 500) begin
        @(negedge clk);
        n++;
      end
      while (sclk_out !== 1'b0 && n < 500) begin
        @(negedge clk);
        n++;
      end
      check(32'(n), 32'(8 * m));
      wait_irq();
      apb(1'b0, sp1_pkg::IDX_DATA, 32'h0);
      apb(1'b1, sp1_pkg::IDX_IRQ_STAT, 32'h3);
    end
    $display("test period done");
  endtask : t_period

  // Slave byte clocked by the far side
  task automatic t_slave;
    apb(1'b1, sp1_pkg::IDX_CONTROL, 32'hB0);
    apb(1'b1, sp1_pkg::IDX_DATA, 32'hC3);
    check({31'h0, irq}, 32'h0);
    peer_go(1'b1, 2'h1, 8'h5A);
    wait_irq();
    check({31'h0, irq}, 32'h1);
    check({24'h0, got}, 32'hC3);
    apb(1'b0, sp1_pkg::IDX_IRQ_STAT, 32'h0);
    check({31'h0, rd[sp1_pkg::IRQ_RX]}, 32'h1);
    apb(1'b0, sp1_pkg::IDX_DATA, 32'h0);
    check(rd, 32'h5A);
    $display("test slave done");
  endtask : t_slave

  // Asynchronous bit time on the transmit pin, undivided source
  task automatic t_async;
    int n;
    apb(1'b1, sp1_pkg::IDX_CONTROL, 32'hD0);
    apb(1'b1, sp1_pkg::IDX_DATA, 32'h55);
    n = 0;
    while (txd_out !== 1'b0 && n < 500) begin
      @(negedge clk);
      n++;
    end
    while (txd_out !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (txd_out !== 1'b0 && n < 500) begin
      @(negedge clk);
      n++;
    end
    check(32'(n), 32'(16 * 2));
    $display("test async done");
  endtask : t_async

  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_master();
    t_period();
    t_slave();
    t_async();
    print_verdict();
  end
endmodule : tb_serial_port_one_sync_async
